// ==== design/dtpm_defs.svh ====
// register offsets, field positions, reset values and codes of the trace pin mux
`ifndef DTPM_DEFS_SVH
`define DTPM_DEFS_SVH

`define DTPM_OFS_PORT_C_LOW_CONFIG  8'h00
`define DTPM_OFS_DEBUG_PIN_CONFIG   8'h04
`define DTPM_OFS_TRACE_CTRL         8'h08
`define DTPM_OFS_GPIO_OUT           8'h0C
`define DTPM_OFS_STATUS             8'h10

`define DTPM_RST_PORT_C_LOW_CONFIG  8'h44
`define DTPM_RST_DEBUG_PIN_CONFIG   8'h00
`define DTPM_RST_TRACE_CTRL         3'h0

`define DTPM_CFG_A_HI               7
`define DTPM_CFG_A_LO               4
`define DTPM_CFG_B_HI               3
`define DTPM_CFG_B_LO               0
`define DTPM_DBG_GPIO_BIT           5
`define DTPM_TRC_EN_BIT             0
`define DTPM_TRC_MODE_HI            2
`define DTPM_TRC_MODE_LO            1

`define DTPM_CODE_ANALOG            4'h0
`define DTPM_CODE_OUT               4'h1
`define DTPM_CODE_IN                4'h4
`define DTPM_CODE_ALT_OUT           4'h9

`endif

// ==== design/dtpm_pkg.sv ====
// types of the trace pin mux
`default_nettype none
package dtpm_pkg;
  typedef enum logic [1:0] {
    DTPM_TRC_ASYNC = 2'h0,
    DTPM_TRC_SYNC1 = 2'h1,
    DTPM_TRC_SYNC2 = 2'h2,
    DTPM_TRC_SYNC4 = 2'h3
  } dtpm_trace_mode_t;

  typedef enum logic [2:0] {
    DTPM_B_SCAN  = 3'b001,
    DTPM_B_GPIO  = 3'b010,
    DTPM_B_TRACE = 3'b100
  } dtpm_b_func_t;
endpackage
`default_nettype wire

// ==== design/dtpm_trace_pin_mux.sv ====
// function selection for the two shared trace pins, with an AHB-Lite register slave
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`include "dtpm_defs.svh"
`default_nettype none

// Overview of operation
// - pin A goes to analog input three only with the analog code in bits 7:4
// - async trace drives pin A when async selected, trace on, alt code in 7:4
// - trace bit zero drives pin A for 1/2/4-wire sync, trace on, alt code 7:4
// - trace bit one drives pin B for 2/4-wire sync, trace on, alt code 3:0
// - pin B is GPIO when debug config bit 5 set or serial-wire without bit one
// - pin B is the scan reset input in scan mode without bit one or debug config bit 5, pull-up on
// - pin B is always sampled as the external interrupt D source
// - scan mode after reset or external reset low; debugger may select serial-wire
module dtpm_trace_pin_mux
  import dtpm_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  input  wire logic        ASYNC_TRACE_OUT,
  input  wire logic        SYNC_TRACE_BIT_ZERO,
  input  wire logic        SYNC_TRACE_BIT_ONE,
  input  wire logic        SERIAL_WIRE_SELECT,
  input  wire logic        EXTERNAL_RESET_PIN_N,
  input  wire logic        PIN_A_I,
  input  wire logic        PIN_B_I,
  output logic             PIN_A_O,
  output logic             PIN_A_OE,
  output logic             PIN_A_ANALOG,
  output logic             PIN_B_O,
  output logic             PIN_B_OE,
  output logic             PIN_B_PULLUP,
  output logic             SCAN_RESET_IN_N,
  output logic             EXT_INTERRUPT_D,
  output logic             SERIAL_WIRE_MODE
);

  function automatic logic code_is(input logic [3:0] field, input logic [3:0] code);
    code_is = (field == code);
  endfunction

  // configuration registers
  logic [7:0]  port_c_low_config_r;
  logic [7:0]  debug_pin_config_r;
  logic [2:0]  trace_ctrl_r;
  logic        gpio_out_r;

  // ahb-lite data phase bookkeeping
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;

  // pin input synchronisers, stage one read only by stage two
  logic        rst_pin_s1_r;
  logic        rst_pin_s2_r;
  logic        pin_a_s1_r;
  logic        pin_a_s2_r;
  logic        pin_b_s1_r;
  logic        pin_b_s2_r;

  logic        serial_wire_r;
  logic        serial_wire_nxt;

  wire         addr_phase  = HSEL & HREADY & HTRANS[1];
  wire         wr_start    = addr_phase & HWRITE;
  wire         rd_start    = addr_phase & ~HWRITE;

  wire [3:0]   cfg_a       = port_c_low_config_r[`DTPM_CFG_A_HI:`DTPM_CFG_A_LO];
  wire [3:0]   cfg_b       = port_c_low_config_r[`DTPM_CFG_B_HI:`DTPM_CFG_B_LO];
  wire         trace_en    = trace_ctrl_r[`DTPM_TRC_EN_BIT];
  wire [1:0]   trace_mode_bits = trace_ctrl_r[`DTPM_TRC_MODE_HI:`DTPM_TRC_MODE_LO];
  dtpm_trace_mode_t trace_mode;
  assign trace_mode = dtpm_trace_mode_t'(trace_mode_bits);

  wire         a_analog    = code_is(cfg_a, `DTPM_CODE_ANALOG);
  wire         a_alt       = code_is(cfg_a, `DTPM_CODE_ALT_OUT);
  wire         b_alt       = code_is(cfg_b, `DTPM_CODE_ALT_OUT);
  wire         b_out       = code_is(cfg_b, `DTPM_CODE_OUT);
  wire         a_async     = a_alt & trace_en & (trace_mode == DTPM_TRC_ASYNC);
  wire         a_sync      = a_alt & trace_en & (trace_mode != DTPM_TRC_ASYNC);
  wire         b_trace     = b_alt & trace_en &
                             ((trace_mode == DTPM_TRC_SYNC2) |
                              (trace_mode == DTPM_TRC_SYNC4));
  wire         b_gpio      = debug_pin_config_r[`DTPM_DBG_GPIO_BIT] | serial_wire_r;

  // trace wins over gpio, gpio over scan reset, so exactly one state is hot
  dtpm_b_func_t b_func;
  assign b_func = b_trace ? DTPM_B_TRACE :
                  (b_gpio ? DTPM_B_GPIO : DTPM_B_SCAN);

  logic        pin_a_o_nxt;
  logic        pin_b_o_nxt;
  logic        pin_b_oe_nxt;
  logic        pin_b_pull_nxt;
  logic        scan_rst_nxt;

  always_comb begin
    pin_a_o_nxt = 1'b0;
    if (a_async) begin
      pin_a_o_nxt = ASYNC_TRACE_OUT;
    end else if (a_sync) begin
      pin_a_o_nxt = SYNC_TRACE_BIT_ZERO;
    end
  end

  always_comb begin
    pin_b_o_nxt    = 1'b0;
    pin_b_oe_nxt   = 1'b0;
    pin_b_pull_nxt = 1'b0;
    scan_rst_nxt   = 1'b1;
    case (b_func)
      DTPM_B_TRACE: begin
        pin_b_o_nxt  = SYNC_TRACE_BIT_ONE;
        pin_b_oe_nxt = 1'b1;
      end
      DTPM_B_GPIO: begin
        pin_b_o_nxt  = gpio_out_r;
        pin_b_oe_nxt = b_out;
      end
      DTPM_B_SCAN: begin
        pin_b_pull_nxt = 1'b1;
        scan_rst_nxt   = pin_b_s2_r;
      end
      default: begin
        pin_b_pull_nxt = 1'b1;
      end
    endcase
  end

  // the debug port protocol detector pulses the select on the same clock;
  // a low external reset pin always falls back to scan mode
  always_comb begin
    serial_wire_nxt = serial_wire_r;
    if (!rst_pin_s2_r) begin
      serial_wire_nxt = 1'b0;
    end else if (SERIAL_WIRE_SELECT) begin
      serial_wire_nxt = 1'b1;
    end
  end

  // bit 7 stays zero so the synced pin A level sits in bit 8
  wire [31:0]  status_word = {23'h00_0000, pin_a_s2_r, 1'b0, b_func, trace_en,
                              serial_wire_r, pin_b_s2_r, a_analog};
  logic [31:0] rd_data_nxt;
  always_comb begin
    case (HADDR)
      `DTPM_OFS_PORT_C_LOW_CONFIG: rd_data_nxt = {24'h00_0000, port_c_low_config_r};
      `DTPM_OFS_DEBUG_PIN_CONFIG:  rd_data_nxt = {24'h00_0000, debug_pin_config_r};
      `DTPM_OFS_TRACE_CTRL:        rd_data_nxt = {29'h0000_0000, trace_ctrl_r};
      `DTPM_OFS_GPIO_OUT:          rd_data_nxt = {31'h0000_0000, gpio_out_r};
      `DTPM_OFS_STATUS:            rd_data_nxt = status_word;
      default:                     rd_data_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      rst_pin_s1_r <= 1'b1;
      rst_pin_s2_r <= 1'b1;
      pin_a_s1_r   <= 1'b0;
      pin_a_s2_r   <= 1'b0;
      pin_b_s1_r   <= 1'b1;
      pin_b_s2_r   <= 1'b1;
    end else begin
      rst_pin_s1_r <= EXTERNAL_RESET_PIN_N;
      rst_pin_s2_r <= rst_pin_s1_r;
      pin_a_s1_r   <= PIN_A_I;
      pin_a_s2_r   <= pin_a_s1_r;
      pin_b_s1_r   <= PIN_B_I;
      pin_b_s2_r   <= pin_b_s1_r;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      HRDATA    <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_start;
      if (wr_start) begin
        wr_addr_r <= HADDR;
      end
      if (rd_start) begin
        HRDATA <= rd_data_nxt;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      port_c_low_config_r <= `DTPM_RST_PORT_C_LOW_CONFIG;
      debug_pin_config_r  <= `DTPM_RST_DEBUG_PIN_CONFIG;
      trace_ctrl_r        <= `DTPM_RST_TRACE_CTRL;
      gpio_out_r          <= 1'b0;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `DTPM_OFS_PORT_C_LOW_CONFIG: port_c_low_config_r <= HWDATA[7:0];
        `DTPM_OFS_DEBUG_PIN_CONFIG:  debug_pin_config_r  <= HWDATA[7:0];
        `DTPM_OFS_TRACE_CTRL:        trace_ctrl_r        <= HWDATA[2:0];
        `DTPM_OFS_GPIO_OUT:          gpio_out_r          <= HWDATA[0];
        default: begin
        end
      endcase
    end
  end

  // every pin output is registered: one cycle of latency on trace data is
  // accepted in exchange for glitch-free pads
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      serial_wire_r    <= 1'b0;
      HREADYOUT        <= 1'b1;
      HRESP            <= 1'b0;
      PIN_A_O          <= 1'b0;
      PIN_A_OE         <= 1'b0;
      PIN_A_ANALOG     <= 1'b0;
      PIN_B_O          <= 1'b0;
      PIN_B_OE         <= 1'b0;
      PIN_B_PULLUP     <= 1'b1;
      SCAN_RESET_IN_N  <= 1'b1;
      EXT_INTERRUPT_D  <= 1'b1;
      SERIAL_WIRE_MODE <= 1'b0;
    end else begin
      serial_wire_r    <= serial_wire_nxt;
      HREADYOUT        <= 1'b1;
      HRESP            <= 1'b0;
      PIN_A_O          <= pin_a_o_nxt;
      PIN_A_OE         <= a_async | a_sync;
      PIN_A_ANALOG     <= a_analog;
      PIN_B_O          <= pin_b_o_nxt;
      PIN_B_OE         <= pin_b_oe_nxt;
      PIN_B_PULLUP     <= pin_b_pull_nxt;
      SCAN_RESET_IN_N  <= scan_rst_nxt;
      EXT_INTERRUPT_D  <= pin_b_s2_r;
      SERIAL_WIRE_MODE <= serial_wire_r;
    end
  end

endmodule
`default_nettype wire

// ==== bench/dtpm_trace_pin_mux_asserts.sv ====
// port assertions of the trace pin mux
`default_nettype none
module dtpm_trace_pin_mux_asserts (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic ASYNC_TRACE_OUT,
  input wire logic SYNC_TRACE_BIT_ZERO,
  input wire logic SERIAL_WIRE_SELECT,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic PIN_B_I,
  input wire logic PIN_A_O,
  input wire logic PIN_A_OE,
  input wire logic PIN_A_ANALOG,
  input wire logic PIN_B_OE,
  input wire logic PIN_B_PULLUP,
  input wire logic SCAN_RESET_IN_N,
  input wire logic EXT_INTERRUPT_D,
  input wire logic SERIAL_WIRE_MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_r;
  // the interrupt path is three flops deep, so its first edges still hold reset values
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  AST_A_EXCL: assert property (PIN_A_ANALOG |-> !PIN_A_OE)
    else $error("pin A analog while driven");
  AST_A_TRACE: assert property (PIN_A_OE |->
    (PIN_A_O == $past(ASYNC_TRACE_OUT) || PIN_A_O == $past(SYNC_TRACE_BIT_ZERO)))
    else $error("pin A drives no trace bit");
  AST_SCAN_NO_DRIVE: assert property (!SCAN_RESET_IN_N |-> !PIN_B_OE)
    else $error("pin B driven in scan use");
  AST_SCAN_PULLUP: assert property (!SCAN_RESET_IN_N |-> PIN_B_PULLUP)
    else $error("pull-up off in scan use");
  AST_IRQ_D: assert property (up_r == 2'h3 |-> EXT_INTERRUPT_D == $past(PIN_B_I, 3))
    else $error("interrupt d not following pin B");
  AST_SW_CLEAR: assert property (!EXTERNAL_RESET_PIN_N [*4] |=> !SERIAL_WIRE_MODE)
    else $error("serial-wire kept during external reset");
  AST_SW_SET: assert property ((EXTERNAL_RESET_PIN_N [*4] ##0 SERIAL_WIRE_SELECT) |->
    ##[1:3] SERIAL_WIRE_MODE)
    else $error("serial-wire not entered");
  AST_SW_NO_SCAN: assert property (SERIAL_WIRE_MODE && $past(SERIAL_WIRE_MODE) |->
    SCAN_RESET_IN_N)
    else $error("scan reset used in serial-wire mode");
  COV_SW: cover property (SERIAL_WIRE_MODE && PIN_B_OE);
  COV_A_TRACE: cover property (PIN_A_OE && PIN_A_O);
  COV_SCAN_LOW: cover property (!SCAN_RESET_IN_N);
endmodule
bind dtpm_trace_pin_mux dtpm_trace_pin_mux_asserts chk (.*);
`default_nettype wire

// ==== bench/dtpm_probe_model.sv ====
// debugger and trace probe as seen from the two shared pins
`default_nettype none
module dtpm_probe_model (
  input  wire logic MCLK,
  input  wire logic PIN_A_O,
  input  wire logic PIN_A_OE,
  input  wire logic PIN_B_O,
  input  wire logic PIN_B_OE,
  input  wire logic PIN_B_PULLUP,
  input  wire logic pb_drv,
  input  wire logic pb_val,
  output logic      PIN_A_I,
  output logic      PIN_B_I
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_last = 1'b0;
  always @(posedge MCLK) a_last <= PIN_A_I;
  // a released pin A has no pull, so it shows a level that keeps changing
  assign PIN_A_I = PIN_A_OE ? PIN_A_O : ~a_last;
  // the probe lets go while the device drives; a floating pin rests on the pull-up when it is on, else shows the inverse of the last pin A level
  assign PIN_B_I = PIN_B_OE ? PIN_B_O : pb_drv ? pb_val : PIN_B_PULLUP ? 1'b1 : ~a_last;
endmodule
`default_nettype wire

// ==== bench/test_dtpm_trace_pin_mux.sv ====
// self-checking bench of the trace pin mux
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module test_dtpm_trace_pin_mux;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] e; logic [31:0] m;} dtpm_note_t;
  logic MCLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
  logic [7:0] HADDR = 8'h00;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic ASYNC_TRACE_OUT = 1'b0, SYNC_TRACE_BIT_ZERO = 1'b0, SYNC_TRACE_BIT_ONE = 1'b0;
  logic SERIAL_WIRE_SELECT = 1'b0, EXTERNAL_RESET_PIN_N = 1'b1, pb_drv = 1'b0, pb_val = 1'b1;
  wire logic HREADY, HREADYOUT, HRESP, PIN_A_I, PIN_B_I, PIN_A_O, PIN_A_OE, PIN_A_ANALOG;
  wire logic PIN_B_O, PIN_B_OE, PIN_B_PULLUP, SCAN_RESET_IN_N, EXT_INTERRUPT_D, SERIAL_WIRE_MODE;
  wire logic [31:0] HRDATA;
  int error_cnt = 0, tests_run = 0;
  logic [31:0] rng = 32'h0001_466E, r;
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h4, 4'h9};
  dtpm_note_t q[$], nt;
  event rd_done;
  always #5 MCLK = ~MCLK;
  assign HREADY = HREADYOUT;
  dtpm_trace_pin_mux DUT (.*);
  dtpm_probe_model probe (.*);
  function logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wt();
    int n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (HREADY !== 1'b1 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // the leading edge leaves one idle cycle, so a read never meets a write still landing
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    wt();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wt();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    xfer(1'b0, a, 32'h0000_0000);
    -> rd_done;
  endtask
  always @(rd_done) begin
    nt = q.pop_front();
    `CHK("hrdata", nt.e, HRDATA & nt.m)
  end
  initial begin
    logic [3:0] c;
    logic [1:0] m;
    logic en, dbg, sw, bt, bo;
    repeat (12) @(posedge MCLK);
    RESET <= 1'b0;
    pb_drv <= 1'b1;
    rd(8'h00, 32'h0000_0044, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0010, 32'h0000_0074);
    `CHK("pullup", 1'b1, PIN_B_PULLUP)
    xfer(1'b1, 8'h0C, 32'h0000_0001);
    for (int k = 0; k < 128; k++) begin
      c = codes[k[1:0]];
      m = k[3:2];
      en = k[4];
      dbg = k[5];
      sw = k[6];
      if (k == 64) begin
        SERIAL_WIRE_SELECT <= 1'b1;
        @(posedge MCLK);
        SERIAL_WIRE_SELECT <= 1'b0;
      end
      r = rnd();
      xfer(1'b1, 8'h08, {29'h0, m, en});
      xfer(1'b1, 8'h04, {26'h0, dbg, 5'h0});
      xfer(1'b1, 8'h00, {24'h0, c, c});
      xfer(1'b1, 8'h0C, {31'h0, r[4]});
      ASYNC_TRACE_OUT <= r[0];
      SYNC_TRACE_BIT_ZERO <= r[1];
      SYNC_TRACE_BIT_ONE <= r[2];
      pb_val <= r[3];
      repeat (5) @(posedge MCLK);
      bt = c == 4'h9 && en && m[1];
      bo = bt || ((dbg || sw) && c == 4'h1);
      `CHK("a_analog", c == 4'h0, PIN_A_ANALOG)
      `CHK("a_oe", c == 4'h9 && en, PIN_A_OE)
      if (c == 4'h9 && en) `CHK("a_o", m == 2'h0 ? r[0] : r[1], PIN_A_O)
      `CHK("b_oe", bo, PIN_B_OE)
      if (bo) `CHK("b_o", bt ? r[2] : r[4], PIN_B_O)
      `CHK("b_pullup", !(bt || dbg || sw), PIN_B_PULLUP)
      `CHK("scan_n", (bt || dbg || sw) ? 1'b1 : r[3], SCAN_RESET_IN_N)
      `CHK("irq_d", PIN_B_I, EXT_INTERRUPT_D)
      `CHK("sw_mode", sw, SERIAL_WIRE_MODE)
      rd(8'h10, {25'h0, bt ? 3'h4 : (dbg || sw) ? 3'h2 : 3'h1, 1'b0, sw, 2'h0},
         32'h0000_0074);
    end
    // a select while the external reset is low must be ignored
    EXTERNAL_RESET_PIN_N <= 1'b0;
    repeat (3) @(posedge MCLK);
    SERIAL_WIRE_SELECT <= 1'b1;
    @(posedge MCLK);
    SERIAL_WIRE_SELECT <= 1'b0;
    repeat (2) @(posedge MCLK);
    EXTERNAL_RESET_PIN_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    `CHK("sw_cleared", 1'b0, SERIAL_WIRE_MODE)
    wrap_up();
  end
endmodule
`default_nettype wire
